// >>> verilog/pdma_regs.vh
// Register map, field positions and reset values of the peripheral DMA channel pair
// Assumes inclusion by bare name; definitions only
`ifndef PDMA_REGS_VH
`define PDMA_REGS_VH
`define PDMA_OFF_RX_PTR 12'h100
`define PDMA_OFF_RX_CNT 12'h104
`define PDMA_OFF_TX_PTR 12'h108
`define PDMA_OFF_TX_CNT 12'h10C
`define PDMA_OFF_RX_NPTR 12'h110
`define PDMA_OFF_RX_NCNT 12'h114
`define PDMA_OFF_TX_NPTR 12'h118
`define PDMA_OFF_TX_NCNT 12'h11C
`define PDMA_OFF_CTRL 12'h120
`define PDMA_OFF_STATE 12'h124
`define PDMA_OFF_FLAGS 12'h128
`define PDMA_OFF_SIZE 12'h12C
`define PDMA_BIT_RX_EN 0
`define PDMA_BIT_RX_DIS 1
`define PDMA_BIT_TX_EN 8
`define PDMA_BIT_TX_DIS 9
`define PDMA_FLAG_END_RX 0
`define PDMA_FLAG_END_TX 1
`define PDMA_FLAG_RX_FULL 2
`define PDMA_FLAG_TX_EMPTY 3
`define PDMA_RST_PTR 32'h00000000
`define PDMA_RST_CNT 16'h0000
`define PDMA_SIZE_BYTE 2'h0
`define PDMA_SIZE_HALF 2'h1
`define PDMA_SIZE_WORD 2'h2
`endif

// >>> verilog/pdma_chan.v
// One channel of the pair: pointer, counter and their next-buffer pair
// Assumes the owner sequences transfers and delivers one done pulse per completed item
`timescale 1ns/1ps
`include "pdma_regs.vh"
module pdma_chan (
  input wire clock_i,
  input wire rst_i,
  input wire wr_ptr_i,
  input wire wr_cnt_i,
  input wire wr_nptr_i,
  input wire wr_ncnt_i,
  input wire [31:0] wdata_i,
  input wire done_i,
  input wire [1:0] size_i,
  output reg [31:0] ptr_o,
  output reg [15:0] cnt_o,
  output reg [31:0] nptr_o,
  output reg [15:0] ncnt_o,
  output reg end_o
);
  reg [31:0] step;
  reg [15:0] cnt_dec;

  // Pointer step by transfer width
  always @* begin
    case (size_i)
      `PDMA_SIZE_BYTE: step = 32'h00000001;
      `PDMA_SIZE_HALF: step = 32'h00000002;
      default: step = 32'h00000004;
    endcase
    cnt_dec = cnt_o - 16'h0001;
  end

  // Software writes win over the transfer update in the same cycle, so a fresh value is never lost
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_o <= `PDMA_RST_PTR;
      cnt_o <= `PDMA_RST_CNT;
      nptr_o <= `PDMA_RST_PTR;
      ncnt_o <= `PDMA_RST_CNT;
      end_o <= 1'b0;
    end else begin
      if (wr_ptr_i) begin
        ptr_o <= wdata_i;
      end else if (done_i && cnt_dec == 16'h0000 && ncnt_o != 16'h0000) begin
        ptr_o <= nptr_o;
      end else if (done_i) begin
        ptr_o <= ptr_o + step;
      end
      if (wr_cnt_i) begin
        cnt_o <= wdata_i[15:0];
      end else if (done_i && cnt_dec == 16'h0000 && ncnt_o != 16'h0000) begin
        cnt_o <= ncnt_o;
      end else if (done_i) begin
        cnt_o <= cnt_dec;
      end
      if (wr_nptr_i) begin
        nptr_o <= wdata_i;
      end
      if (wr_ncnt_i) begin
        ncnt_o <= wdata_i[15:0];
      end else if (!wr_cnt_i && done_i && cnt_dec == 16'h0000) begin
        ncnt_o <= `PDMA_RST_CNT;
      end
      // Set wins over the counter-write clear
      if (done_i && cnt_dec == 16'h0000 && ncnt_o == 16'h0000) begin
        end_o <= 1'b1;
      end else if (wr_cnt_i || wr_ncnt_i) begin
        end_o <= 1'b0;
      end
    end
  end
endmodule // pdma_chan

// >>> verilog/pdma_pair.v
// Peripheral DMA channel pair: one receive and one transmit channel, APB registers, bus master
// Assumes an APB master for registers, a simple request/grant memory bus and a peripheral
// whose ready lines are asynchronous levels and whose holding registers have their own ports.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "pdma_regs.vh"
module pdma_pair (
  input wire clock_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Peripheral side
  input wire peripheral_rx_ready_i,
  input wire peripheral_tx_ready_i,
  input wire [31:0] rx_holding_register_i,
  output reg rx_holding_read_o,
  output reg [31:0] tx_holding_data_o,
  output reg tx_holding_write_o,
  output wire rx_buffer_end_flag_o,
  output wire tx_buffer_end_flag_o,
  output wire rx_both_buffers_full_flag_o,
  output wire tx_both_buffers_empty_flag_o,
  // Memory bus master
  output reg mem_req_o,
  input wire mem_gnt_i,
  output reg mem_write_o,
  output reg [31:0] mem_addr_o,
  output reg [1:0] mem_size_o,
  output reg [31:0] mem_wdata_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i
);
  // Sequencer states: wait for a trigger, for the grant, for the memory answer, then step counters
  localparam ST_IDLE = 2'h0;
  localparam ST_GRANT = 2'h1;
  localparam ST_MEM = 2'h2;
  localparam ST_DONE = 2'h3;

  // Sequencer and control state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg dir_tx_r;
  reg rx_en_r;
  reg tx_en_r;
  reg [1:0] size_r;
  // Three-stage pin synchronisers and their filtered levels
  reg [2:0] rx_sync_r;
  reg [2:0] tx_sync_r;
  reg rx_lvl_r;
  reg tx_lvl_r;
  // Pending triggers, one per channel
  reg rx_pend_r;
  reg tx_pend_r;
  // Registered read data and one-cycle completion strobes
  reg [31:0] rdata_r;
  reg done_rx;
  reg done_tx;
  // Channel register views
  wire [31:0] rx_ptr;
  wire [15:0] rx_cnt;
  wire [31:0] rx_nptr;
  wire [15:0] rx_ncnt;
  wire [31:0] tx_ptr;
  wire [15:0] tx_cnt;
  wire [31:0] tx_nptr;
  wire [15:0] tx_ncnt;
  wire rx_end;
  wire tx_end;
  // Decoded strobes and trigger qualifiers
  wire wr_acc;
  wire rx_rise;
  wire tx_rise;
  wire rx_live;
  wire tx_live;

  // APB answers in the access cycle itself; a write takes effect at that edge
  assign pready_o = 1'b1;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign prdata_o = rdata_r;

  // Unmapped offsets flag an error so software sees a bad address
  assign pslverr_o = psel_i && penable_i && ((paddr_i[1:0] != 2'h0) ||
    (paddr_i < `PDMA_OFF_RX_PTR) || (paddr_i > `PDMA_OFF_SIZE));

  // Pin synchronisers: a change counts once stages two and three agree
  // Stage one is read by stage two only, so a metastable value never reaches the logic
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sync_r <= 3'h0;
      tx_sync_r <= 3'h0;
      rx_lvl_r <= 1'b0;
      tx_lvl_r <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], peripheral_rx_ready_i};
      tx_sync_r <= {tx_sync_r[1:0], peripheral_tx_ready_i};
      if (rx_sync_r[2] == rx_sync_r[1]) begin
        rx_lvl_r <= rx_sync_r[2];
      end
      if (tx_sync_r[2] == tx_sync_r[1]) begin
        tx_lvl_r <= tx_sync_r[2];
      end
    end
  end

  // A synchronised ready level sets the pending trigger while its channel is not being served.
  // Limitation: the level is looked at again once the sequencer is idle, so a peripheral must
  // drop ready within a few cycles of raising it, or the same item is moved twice
  assign rx_rise = rx_lvl_r && !rx_pend_r && !(state_r != ST_IDLE && !dir_tx_r);
  assign tx_rise = tx_lvl_r && !tx_pend_r && !(state_r != ST_IDLE && dir_tx_r);
  // Only enabled channels with work left accept triggers
  assign rx_live = rx_en_r && (rx_cnt != 16'h0000);
  assign tx_live = tx_en_r && (tx_cnt != 16'h0000);

  // Control, size and pending-trigger state
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      size_r <= `PDMA_SIZE_BYTE;
      rx_pend_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else begin
      // Disable beats enable within one write, in both directions
      if (wr_acc && paddr_i == `PDMA_OFF_CTRL) begin
        if (pwdata_i[`PDMA_BIT_RX_DIS]) begin
          rx_en_r <= 1'b0;
        end else if (pwdata_i[`PDMA_BIT_RX_EN]) begin
          rx_en_r <= 1'b1;
        end
        if (pwdata_i[`PDMA_BIT_TX_DIS]) begin
          tx_en_r <= 1'b0;
        end else if (pwdata_i[`PDMA_BIT_TX_EN]) begin
          tx_en_r <= 1'b1;
        end
      end
      if (wr_acc && paddr_i == `PDMA_OFF_SIZE) begin
        size_r <= pwdata_i[1:0];
      end
      // Capture wins over the service clear
      if (rx_rise && rx_live) begin
        rx_pend_r <= 1'b1;
      end else if (done_rx || !rx_live) begin
        rx_pend_r <= 1'b0;
      end
      if (tx_rise && tx_live) begin
        tx_pend_r <= 1'b1;
      end else if (done_tx || !tx_live) begin
        tx_pend_r <= 1'b0;
      end
    end
  end

  // Transfer sequencer: one item per trip, receive served first
  always @* begin
    state_nxt = state_r;
    done_rx = 1'b0;
    done_tx = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (rx_pend_r || tx_pend_r) begin
          state_nxt = ST_GRANT;
        end
      end
      ST_GRANT: begin
        // The arbiter may hold the grant back for any number of cycles
        if (mem_gnt_i) begin
          state_nxt = ST_MEM;
        end
      end
      ST_MEM: begin
        // Memory latency is left to the far side
        if (mem_ack_i) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
        done_rx = !dir_tx_r;
        done_tx = dir_tx_r;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Bus master and holding register strobes
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      dir_tx_r <= 1'b0;
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_size_o <= `PDMA_SIZE_BYTE;
      mem_wdata_o <= 32'h00000000;
      rx_holding_read_o <= 1'b0;
      tx_holding_data_o <= 32'h00000000;
      tx_holding_write_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_holding_read_o <= 1'b0;
      tx_holding_write_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Receive pending beats transmit pending
          if (rx_pend_r) begin
            dir_tx_r <= 1'b0;
            mem_req_o <= 1'b1;
          end else if (tx_pend_r) begin
            dir_tx_r <= 1'b1;
            mem_req_o <= 1'b1;
          end
        end
        ST_GRANT: begin
          if (mem_gnt_i) begin
            mem_size_o <= size_r;
            if (!dir_tx_r) begin
              // Pointer sampled here so a rewrite is honoured
              rx_holding_read_o <= 1'b1;
              mem_write_o <= 1'b1;
              mem_addr_o <= rx_ptr;
              mem_wdata_o <= rx_holding_register_i;
            end else begin
              mem_write_o <= 1'b0;
              mem_addr_o <= tx_ptr;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_write_o <= 1'b0;
            // Read data goes straight to the transmit holding register
            if (dir_tx_r) begin
              tx_holding_data_o <= mem_rdata_i;
              tx_holding_write_o <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          // The done strobe steps the channel counters in this cycle
          mem_req_o <= 1'b0;
        end
        default: begin
          mem_req_o <= 1'b0;
        end
      endcase
    end
  end

  // Receive channel
  pdma_chan u_rx (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_ptr_i(wr_acc && paddr_i == `PDMA_OFF_RX_PTR),
    .wr_cnt_i(wr_acc && paddr_i == `PDMA_OFF_RX_CNT),
    .wr_nptr_i(wr_acc && paddr_i == `PDMA_OFF_RX_NPTR),
    .wr_ncnt_i(wr_acc && paddr_i == `PDMA_OFF_RX_NCNT),
    .wdata_i(pwdata_i),
    .done_i(done_rx),
    .size_i(size_r),
    .ptr_o(rx_ptr),
    .cnt_o(rx_cnt),
    .nptr_o(rx_nptr),
    .ncnt_o(rx_ncnt),
    .end_o(rx_end)
  );

  // Transmit channel
  pdma_chan u_tx (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_ptr_i(wr_acc && paddr_i == `PDMA_OFF_TX_PTR),
    .wr_cnt_i(wr_acc && paddr_i == `PDMA_OFF_TX_CNT),
    .wr_nptr_i(wr_acc && paddr_i == `PDMA_OFF_TX_NPTR),
    .wr_ncnt_i(wr_acc && paddr_i == `PDMA_OFF_TX_NCNT),
    .wdata_i(pwdata_i),
    .done_i(done_tx),
    .size_i(size_r),
    .ptr_o(tx_ptr),
    .cnt_o(tx_cnt),
    .nptr_o(tx_nptr),
    .ncnt_o(tx_ncnt),
    .end_o(tx_end)
  );

  // Status levels toward the peripheral status register
  // Levels follow the counters directly, so a counter write shows at once
  assign rx_buffer_end_flag_o = (rx_cnt == 16'h0000);
  assign tx_buffer_end_flag_o = (tx_cnt == 16'h0000);
  assign rx_both_buffers_full_flag_o = (rx_cnt == 16'h0000) && (rx_ncnt == 16'h0000);
  assign tx_both_buffers_empty_flag_o = (tx_cnt == 16'h0000) && (tx_ncnt == 16'h0000);

  // Read data registered in the setup cycle; reads have no side effect
  // The write-only control offset and unmapped offsets read as zero
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `PDMA_OFF_RX_PTR: rdata_r <= rx_ptr;
        `PDMA_OFF_RX_CNT: rdata_r <= {16'h0000, rx_cnt};
        `PDMA_OFF_TX_PTR: rdata_r <= tx_ptr;
        `PDMA_OFF_TX_CNT: rdata_r <= {16'h0000, tx_cnt};
        `PDMA_OFF_RX_NPTR: rdata_r <= rx_nptr;
        `PDMA_OFF_RX_NCNT: rdata_r <= {16'h0000, rx_ncnt};
        `PDMA_OFF_TX_NPTR: rdata_r <= tx_nptr;
        `PDMA_OFF_TX_NCNT: rdata_r <= {16'h0000, tx_ncnt};
        `PDMA_OFF_STATE: rdata_r <= {23'h0, tx_en_r, 7'h0, rx_en_r};
        `PDMA_OFF_FLAGS: rdata_r <= {28'h0000000, tx_both_buffers_empty_flag_o, rx_both_buffers_full_flag_o,
          tx_end, rx_end};
        `PDMA_OFF_SIZE: rdata_r <= {30'h0, size_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end
endmodule // pdma_pair

// >>> tb/pdma_pair_chk.sv
// Port checker for the peripheral DMA channel pair
// Assumes one clock domain and the asynchronous reset rst_i
`timescale 1ns/1ps
module pdma_pair_chk (
  input wire clock_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire pslverr_o,
  input wire rx_holding_read_o,
  input wire [31:0] tx_holding_data_o,
  input wire tx_holding_write_o,
  input wire rx_buffer_end_flag_o,
  input wire tx_buffer_end_flag_o,
  input wire rx_both_buffers_full_flag_o,
  input wire tx_both_buffers_empty_flag_o,
  input wire mem_req_o,
  input wire mem_write_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Aligned word inside the register block
  wire in_map = paddr_i >= 12'h100 && paddr_i <= 12'h12C && paddr_i[1:0] == 2'h0;

  a_map_error: assert property (psel_i && penable_i && !in_map |-> pslverr_o)
    else $error("no slave error off the map");
  a_map_ok: assert property (psel_i && penable_i && in_map |-> !pslverr_o)
    else $error("slave error inside the map");
  a_rx_full_end: assert property (rx_both_buffers_full_flag_o |-> rx_buffer_end_flag_o)
    else $error("rx full without rx end");
  a_tx_empty_end: assert property (tx_both_buffers_empty_flag_o |-> tx_buffer_end_flag_o)
    else $error("tx empty without tx end");
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o)
    else $error("bus request dropped before completion");
  a_ack_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("bus request kept after completion");
  a_rx_reads_hold: assert property (rx_holding_read_o |-> mem_req_o && mem_write_o)
    else $error("holding read without memory write");
  a_tx_data_ack: assert property (tx_holding_write_o |->
    $past(mem_ack_i && mem_req_o && !mem_write_o) && tx_holding_data_o == $past(mem_rdata_i))
    else $error("tx holding write without memory read data");
  // The end level may only rise after a transfer or a register write
  a_rx_end_cause: assert property ($rose(rx_buffer_end_flag_o) |->
    $past(mem_ack_i, 2) || $past(mem_ack_i) || $past(psel_i && penable_i && pwrite_i))
    else $error("rx end rose without cause");
endmodule // pdma_pair_chk

bind pdma_pair pdma_pair_chk i_pdma_pair_chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o),
  .rx_holding_read_o(rx_holding_read_o), .tx_holding_data_o(tx_holding_data_o),
  .tx_holding_write_o(tx_holding_write_o), .rx_buffer_end_flag_o(rx_buffer_end_flag_o),
  .tx_buffer_end_flag_o(tx_buffer_end_flag_o), .rx_both_buffers_full_flag_o(rx_both_buffers_full_flag_o),
  .tx_both_buffers_empty_flag_o(tx_both_buffers_empty_flag_o), .mem_req_o(mem_req_o),
  .mem_write_o(mem_write_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));

// >>> tb/pdma_mem.sv
// Memory and bus arbiter at the far side of the DMA pair
// Word model only: transfer size is ignored, each access touches one aligned word
`timescale 1ns/1ps
module pdma_mem (
  input wire clock_i,
  input wire rst_i,
  input wire slow_i,
  input wire req_i,
  input wire write_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  output reg gnt_o,
  output reg ack_o,
  output reg [31:0] rdata_o,
  output reg [31:0] last_addr_o,
  output reg [31:0] last_data_o
);
  reg [31:0] mem_r [0:255];
  reg [1:0] ph_r;
  reg [1:0] wait_r;
  integer k;
  // Known contents so read data follows from the address
  initial for (k = 0; k < 256; k = k + 1) mem_r[k] = 32'hC0DE0000 + k;
  // Grant, one cycle for the master to load its address, then the completion pulse
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r <= 2'h0;
      wait_r <= 2'h0;
      gnt_o <= 1'b0;
      ack_o <= 1'b0;
      rdata_o <= 32'h00000000;
      last_addr_o <= 32'h00000000;
      last_data_o <= 32'h00000000;
    end else begin
      ack_o <= 1'b0;
      gnt_o <= 1'b0;
      rdata_o <= ~rdata_o; // Undriven bus: value moves so stale data never matches
      case (ph_r)
        2'h0: if (req_i && !ack_o) begin
          if (wait_r == (slow_i ? 2'h3 : 2'h0)) begin
            gnt_o <= 1'b1;
            ph_r <= 2'h1;
            wait_r <= 2'h0;
          end else begin
            wait_r <= wait_r + 2'h1;
          end
        end
        2'h1: ph_r <= 2'h2;
        default: begin
          ack_o <= 1'b1;
          ph_r <= 2'h0;
          if (write_i) begin
            mem_r[addr_i[9:2]] <= wdata_i;
            last_addr_o <= addr_i;
            last_data_o <= wdata_i;
          end else begin
            rdata_o <= mem_r[addr_i[9:2]];
          end
        end
      endcase
    end
  end
endmodule // pdma_mem

// >>> tb/pdma_pair_tb.sv
// Self-checking bench for the DMA pair: APB register tasks and transfer items
// Assumes the memory model above and the bound port checker
`timescale 1ns/1ps
module pdma_pair_tb;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_rdy = 1'b0, tx_rdy = 1'b0, slow = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000, rx_hold = 32'h5AA5F00F;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata, tx_data, last_addr, last_data;
  wire [1:0] mem_size;
  wire pready, pslverr, rx_end, tx_end, rx_full, tx_empty, mem_req, mem_gnt, mem_write, mem_ack;
  integer err_count = 0, cmp_count = 0, i, s;
  reg [31:0] q;
  reg e, ack_wr;
  reg [1:0] ack_size;

  pdma_pair i_pdma_pair (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .peripheral_rx_ready_i(rx_rdy), .peripheral_tx_ready_i(tx_rdy),
    .rx_holding_register_i(rx_hold), .rx_holding_read_o(), .tx_holding_data_o(tx_data),
    .tx_holding_write_o(), .rx_buffer_end_flag_o(rx_end), .tx_buffer_end_flag_o(tx_end),
    .rx_both_buffers_full_flag_o(rx_full), .tx_both_buffers_empty_flag_o(tx_empty), .mem_req_o(mem_req),
    .mem_gnt_i(mem_gnt), .mem_write_o(mem_write), .mem_addr_o(mem_addr), .mem_size_o(mem_size),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
  pdma_mem i_pdma_mem (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow), .req_i(mem_req),
    .write_i(mem_write), .addr_i(mem_addr), .wdata_i(mem_wdata), .gnt_o(mem_gnt), .ack_o(mem_ack),
    .rdata_o(mem_rdata), .last_addr_o(last_addr), .last_data_o(last_data));

  always #10 clock_i = ~clock_i;

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; a free cycle follows so the next setup never collides
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) @(posedge clock_i);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task rd(input [11:0] a, input [31:0] x);
    begin
      apb(a, 1'b0, 32'h00000000);
      chk(q, x);
    end
  endtask
  // Raise ready levels for three cycles, then wait for a completion; x says whether one is due.
  // A level left high until the item ends would be taken as a second item once the block is idle
  task item(input r, input t, input x);
    begin
      rx_rdy <= r;
      tx_rdy <= t;
      i = 0;
      @(posedge clock_i);
      while (mem_ack !== 1'b1 && i < 40) begin
        if (i == 2) begin
          rx_rdy <= 1'b0;
          tx_rdy <= 1'b0;
        end
        @(posedge clock_i);
        i = i + 1;
      end
      ack_wr = mem_write;
      ack_size = mem_size;
      chk(i < 40, x);
      if (i < 3) begin
        rx_rdy <= 1'b0;
        tx_rdy <= 1'b0;
      end
      repeat (2) @(posedge clock_i);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Whole run is a few hundred cycles; this limit cuts a hang short
  initial begin
    #(20 * 20000);
    err_count = err_count + 1;
    give_verdict;
  end

  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (s = 0; s < 10; s = s + 1) if (s != 8) rd(12'h100 + 12'(4 * s), 32'h00000000);
    chk({rx_end, tx_end, rx_full, tx_empty}, 4'hF);
    rd(12'h130, 32'h00000000);
    chk(e, 1'b1);
    apb(12'h100, 1'b1, 32'hFFFFFFFC);
    rd(12'h100, 32'hFFFFFFFC);
    apb(12'h104, 1'b1, 32'h00012345);
    rd(12'h104, 32'h00002345);
    $display("registers done");
    apb(12'h120, 1'b1, 32'h00000101);
    rd(12'h124, 32'h00000101);
    apb(12'h124, 1'b1, 32'h00000000);
    rd(12'h124, 32'h00000101);
    apb(12'h120, 1'b1, 32'h00000003);
    rd(12'h124, 32'h00000100);
    apb(12'h120, 1'b1, 32'h00000200);
    rd(12'h124, 32'h00000000);
    item(1'b1, 1'b0, 1'b0);
    rd(12'h104, 32'h00002345);
    $display("control done");
    apb(12'h120, 1'b1, 32'h00000001);
    for (s = 0; s < 3; s = s + 1) begin
      apb(12'h12C, 1'b1, 32'(s));
      apb(12'h100, 1'b1, 32'h00000200);
      apb(12'h104, 1'b1, 32'h00000002);
      item(1'b1, 1'b0, 1'b1);
      chk(last_addr, 32'h00000200);
      chk(last_data, 32'h5AA5F00F);
      chk(ack_size, s);
      rd(12'h100, 32'h00000200 + (32'h1 << s));
      rd(12'h104, 32'h00000001);
      item(1'b1, 1'b0, 1'b1);
      chk({rx_end, rx_full}, 2'h3);
      item(1'b1, 1'b0, 1'b0);
    end
    apb(12'h128, 1'b0, 32'h00000000);
    chk(q[0], 1'b1);
    apb(12'h114, 1'b1, 32'h00000000);
    apb(12'h128, 1'b0, 32'h00000000);
    chk(q[0], 1'b0);
    $display("receive done");
    apb(12'h100, 1'b1, 32'h00000300);
    apb(12'h104, 1'b1, 32'h00000001);
    apb(12'h110, 1'b1, 32'h00000400);
    apb(12'h114, 1'b1, 32'h00000002);
    item(1'b1, 1'b0, 1'b1);
    rd(12'h100, 32'h00000400);
    rd(12'h104, 32'h00000002);
    rd(12'h114, 32'h00000000);
    chk({rx_end, rx_full}, 2'h0);
    apb(12'h100, 1'b1, 32'h00000600);
    apb(12'h104, 1'b1, 32'h00000005);
    item(1'b1, 1'b0, 1'b1);
    chk(last_addr, 32'h00000600);
    rd(12'h104, 32'h00000004);
    $display("chaining done");
    slow <= 1'b1;
    apb(12'h108, 1'b1, 32'h00000020);
    apb(12'h10C, 1'b1, 32'h00000002);
    apb(12'h120, 1'b1, 32'h00000100);
    item(1'b1, 1'b1, 1'b1);
    chk(ack_wr, 1'b1);
    item(1'b0, 1'b0, 1'b1);
    chk(ack_wr, 1'b0);
    item(1'b0, 1'b1, 1'b1);
    chk(ack_wr, 1'b0);
    chk(tx_data, 32'hC0DE0009);
    chk({tx_end, tx_empty}, 2'h3);
    rd(12'h108, 32'h00000028);
    $display("transmit done");
    give_verdict;
  end
endmodule // pdma_pair_tb
